// ---- core/rtcf_defs.vh ----
// shared constants of the clock flag and sram port block
`ifndef RTCF_DEFS_VH
`define RTCF_DEFS_VH

// ------------------------------------------------------------
// register addresses on the multiplexed bus
// ------------------------------------------------------------
`define RTCF_ADDR_RATE_CTRL   8'h0A
`define RTCF_ADDR_MAIN_CTRL   8'h0B
`define RTCF_ADDR_IRQ_FLAGS   8'h0C
`define RTCF_ADDR_BATT_STATUS 8'h0D

// ------------------------------------------------------------
// main control register fields
// ------------------------------------------------------------
`define RTCF_CTRL_FREEZE_BIT  7
`define RTCF_CTRL_PIE_BIT     6
`define RTCF_CTRL_AIE_BIT     5
`define RTCF_CTRL_UIE_BIT     4

// ------------------------------------------------------------
// interrupt flag register fields
// ------------------------------------------------------------
`define RTCF_FLAG_REQUEST_PENDING_FLAG_BIT    7
`define RTCF_FLAG_PF_BIT      6
`define RTCF_FLAG_AF_BIT      5
`define RTCF_FLAG_UF_BIT      4

// ------------------------------------------------------------
// battery status field
// ------------------------------------------------------------
`define RTCF_BATT_GOOD_BIT    7

// ------------------------------------------------------------
// rate control field and tap count
// ------------------------------------------------------------
`define RTCF_RATE_SEL_MSB     3
`define RTCF_RATE_SEL_LSB     0
`define RTCF_TAP_LAST         13

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RTCF_RST_RATE_CTRL    7'h00
`define RTCF_RST_MAIN_CTRL    8'h00
`define RTCF_RST_BYTE         8'h00

// ------------------------------------------------------------
// sram geometry
// ------------------------------------------------------------
`define RTCF_SRAM_AW          12
`define RTCF_SRAM_DEPTH       4096

`endif

// ---- core/rtcf_sram.v ----
// 4096 by 8 storage array with registered read data
`include "rtcf_defs.vh"

module rtcf_sram (
    input  wire                     clk,
    input  wire [`RTCF_SRAM_AW-1:0] addr,
    input  wire [7:0]               wdata,
    input  wire                     we,
    output reg  [7:0]               rdata
);

    // ------------------------------------------------------------
    // array
    // ------------------------------------------------------------
    reg [7:0] mem [0:`RTCF_SRAM_DEPTH-1];

    // ------------------------------------------------------------
    // write port and registered read port
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end

endmodule // rtcf_sram

// ---- core/rtcf_top.v ----
// interrupt flags, battery status and sram access port of the clock
`include "rtcf_defs.vh"

module rtcf_top (
    input  wire        CLK_SYS,
    input  wire        RST,
    input  wire [7:0]  MUXED_ADDR_DATA_BUS_IN,
    output reg  [7:0]  MUXED_ADDR_DATA_BUS_OUT,
    output reg         MUXED_ADDR_DATA_BUS_OE_N,
    input  wire        ALE,
    input  wire        CS_N,
    input  wire        RD_N,
    input  wire        WR_N,
    input  wire        LOW_ADDR_STROBE_N,
    input  wire        HIGH_ADDR_STROBE_N,
    input  wire        RAM_READ_ENABLE_N,
    input  wire        RAM_STORE_ENABLE_N,
    input  wire [15:0] DIVIDER_TAPS,
    input  wire        ALARM_MATCH,
    input  wire        UPDATE_DONE,
    input  wire        POWER_GOOD,
    input  wire        BACKUP_ENERGY_GOOD,
    output reg         IRQ_PIN_OUT,
    output reg         IRQ_PIN_OE_N
);

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    function rose;
        input prev;
        input cur;
        begin
            rose = ~prev & cur;
        end
    endfunction

    function fell;
        input prev;
        input cur;
        begin
            fell = prev & ~cur;
        end
    endfunction

    // rate 0 and rates past the last tap select no tap
    function tap_pick;
        input [3:0]  rate;
        input [15:0] taps;
        begin
            if (rate == 4'h0 || rate > `RTCF_TAP_LAST) begin
                tap_pick = 1'b0;
            end else begin
                tap_pick = taps[rate];
            end
        end
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    reg        low_strobe_q;
    reg        high_strobe_q;
    reg        store_en_q;
    reg        ale_q;
    reg        rd_q;
    reg        wr_q;
    reg        tap_q;
    reg [7:0]  low_shadow_q;
    reg [3:0]  high_shadow_q;
    reg [7:0]  ram_wdata_q;
    reg [7:0]  ale_shadow_q;
    reg [7:0]  reg_wdata_q;
    reg [7:0]  addr_low_q;
    reg [3:0]  addr_high_q;
    reg [7:0]  reg_addr_q;
    reg [6:0]  rate_ctrl_q;
    reg [7:0]  main_ctrl_q;
    reg        periodic_event_flag_q;
    reg        alarm_match_flag_q;
    reg        update_done_flag_q;
    reg        request_pending_flag_q;

    reg        periodic_event_flag_d;
    reg        alarm_match_flag_d;
    reg        update_done_flag_d;
    reg        request_pending_flag_d;
    reg [7:0]  main_ctrl_d;
    reg [7:0]  reg_rdata;

    wire [7:0] ram_rdata;
    wire       ram_we;
    wire       tap_now;
    wire       flag_read;
    wire       reg_rd_start;
    wire       reg_wr_end;
    wire [3:0] rate_select;
    wire       periodic_irq_enable;
    wire       alarm_irq_enable;
    wire       update_done_irq_enable;

    assign rate_select = rate_ctrl_q[`RTCF_RATE_SEL_MSB:`RTCF_RATE_SEL_LSB];
    assign periodic_irq_enable    = main_ctrl_q[`RTCF_CTRL_PIE_BIT];
    assign alarm_irq_enable       = main_ctrl_q[`RTCF_CTRL_AIE_BIT];
    assign update_done_irq_enable = main_ctrl_q[`RTCF_CTRL_UIE_BIT];

    // ------------------------------------------------------------
    // previous input levels for edge detection
    // ------------------------------------------------------------
    always @(posedge CLK_SYS) begin
        if (RST) begin
            low_strobe_q  <= 1'b1;
            high_strobe_q <= 1'b1;
            store_en_q    <= 1'b1;
            ale_q         <= 1'b0;
            rd_q          <= 1'b1;
            wr_q          <= 1'b1;
            tap_q         <= 1'b0;
        end else begin
            low_strobe_q  <= LOW_ADDR_STROBE_N;
            high_strobe_q <= HIGH_ADDR_STROBE_N;
            store_en_q    <= RAM_STORE_ENABLE_N;
            ale_q         <= ALE;
            rd_q          <= RD_N;
            wr_q          <= WR_N;
            tap_q         <= tap_now;
        end
    end

    // ------------------------------------------------------------
    // sram address and data latches
    // ------------------------------------------------------------
    // bus value is followed while a strobe is low and kept at its
    // rising edge, so zero hold time after the edge is tolerated
    always @(posedge CLK_SYS) begin
        if (RST) begin
            low_shadow_q  <= `RTCF_RST_BYTE;
            high_shadow_q <= 4'h0;
            ram_wdata_q   <= `RTCF_RST_BYTE;
            addr_low_q    <= `RTCF_RST_BYTE;
            addr_high_q   <= 4'h0;
        end else begin
            if (!LOW_ADDR_STROBE_N) begin
                low_shadow_q <= MUXED_ADDR_DATA_BUS_IN;
            end
            if (!HIGH_ADDR_STROBE_N) begin
                high_shadow_q <= MUXED_ADDR_DATA_BUS_IN[3:0];
            end
            if (!RAM_STORE_ENABLE_N) begin
                ram_wdata_q <= MUXED_ADDR_DATA_BUS_IN;
            end
            // halves only change on their own strobe
            if (rose(low_strobe_q, LOW_ADDR_STROBE_N)) begin
                addr_low_q <= low_shadow_q;
            end
            if (rose(high_strobe_q, HIGH_ADDR_STROBE_N)) begin
                addr_high_q <= high_shadow_q;
            end
        end
    end

    // ------------------------------------------------------------
    // sram write and array
    // ------------------------------------------------------------
    // store at end of the write pulse, only once power is good
    assign ram_we = rose(store_en_q, RAM_STORE_ENABLE_N) & POWER_GOOD;

    rtcf_sram u_sram (
        .clk   (CLK_SYS),
        .addr  ({addr_high_q, addr_low_q}),
        .wdata (ram_wdata_q),
        .we    (ram_we),
        .rdata (ram_rdata)
    );

    // ------------------------------------------------------------
    // register address and write data capture
    // ------------------------------------------------------------
    always @(posedge CLK_SYS) begin
        if (RST) begin
            ale_shadow_q <= `RTCF_RST_BYTE;
            reg_addr_q   <= `RTCF_RST_BYTE;
            reg_wdata_q  <= `RTCF_RST_BYTE;
        end else begin
            if (ALE) begin
                ale_shadow_q <= MUXED_ADDR_DATA_BUS_IN;
            end
            if (fell(ale_q, ALE)) begin
                reg_addr_q <= ale_shadow_q;
            end
            if (!WR_N) begin
                reg_wdata_q <= MUXED_ADDR_DATA_BUS_IN;
            end
        end
    end

    // register cycles only count with chip select
    assign reg_rd_start = ~CS_N & fell(rd_q, RD_N);
    assign reg_wr_end   = ~CS_N & rose(wr_q, WR_N);
    assign flag_read    = reg_rd_start & (reg_addr_q == `RTCF_ADDR_IRQ_FLAGS);

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always @* begin
        main_ctrl_d = main_ctrl_q;
        if (reg_wr_end && reg_addr_q == `RTCF_ADDR_MAIN_CTRL) begin
            main_ctrl_d = reg_wdata_q;
            // freeze going high forces the update enable off
            if (reg_wdata_q[`RTCF_CTRL_FREEZE_BIT] &&
                !main_ctrl_q[`RTCF_CTRL_FREEZE_BIT]) begin
                main_ctrl_d[`RTCF_CTRL_UIE_BIT] = 1'b0;
            end
        end
    end

    always @(posedge CLK_SYS) begin
        if (RST) begin
            rate_ctrl_q <= `RTCF_RST_RATE_CTRL;
            main_ctrl_q <= `RTCF_RST_MAIN_CTRL;
        end else begin
            main_ctrl_q <= main_ctrl_d;
            if (reg_wr_end && reg_addr_q == `RTCF_ADDR_RATE_CTRL) begin
                rate_ctrl_q <= reg_wdata_q[6:0];
            end
        end
    end

    // ------------------------------------------------------------
    // event flags
    // ------------------------------------------------------------
    assign tap_now = tap_pick(rate_select, DIVIDER_TAPS);

    // an event in the clearing cycle wins over the clear
    always @* begin
        periodic_event_flag_d = (periodic_event_flag_q & ~flag_read)
                              | rose(tap_q, tap_now);
        alarm_match_flag_d    = (alarm_match_flag_q & ~flag_read)
                              | ALARM_MATCH;
        update_done_flag_d    = (update_done_flag_q & ~flag_read)
                              | UPDATE_DONE;
        request_pending_flag_d =
              (periodic_event_flag_d & main_ctrl_d[`RTCF_CTRL_PIE_BIT])
            | (alarm_match_flag_d & main_ctrl_d[`RTCF_CTRL_AIE_BIT])
            | (update_done_flag_d & main_ctrl_d[`RTCF_CTRL_UIE_BIT]);
    end

    always @(posedge CLK_SYS) begin
        if (RST) begin
            periodic_event_flag_q  <= 1'b0;
            alarm_match_flag_q     <= 1'b0;
            update_done_flag_q     <= 1'b0;
            request_pending_flag_q <= 1'b0;
        end else begin
            periodic_event_flag_q  <= periodic_event_flag_d;
            alarm_match_flag_q     <= alarm_match_flag_d;
            update_done_flag_q     <= update_done_flag_d;
            request_pending_flag_q <= request_pending_flag_d;
        end
    end

    // ------------------------------------------------------------
    // register read mux
    // ------------------------------------------------------------
    always @* begin
        reg_rdata = `RTCF_RST_BYTE;
        case (reg_addr_q)
            `RTCF_ADDR_RATE_CTRL: begin
                reg_rdata = {1'b0, rate_ctrl_q};
            end
            `RTCF_ADDR_MAIN_CTRL: begin
                reg_rdata = main_ctrl_q;
            end
            `RTCF_ADDR_IRQ_FLAGS: begin
                // low nibble stays zero
                reg_rdata[`RTCF_FLAG_REQUEST_PENDING_FLAG_BIT] = request_pending_flag_q;
                reg_rdata[`RTCF_FLAG_PF_BIT]   = periodic_event_flag_q;
                reg_rdata[`RTCF_FLAG_AF_BIT]   = alarm_match_flag_q;
                reg_rdata[`RTCF_FLAG_UF_BIT]   = update_done_flag_q;
            end
            `RTCF_ADDR_BATT_STATUS: begin
                // only the top bit carries state
                reg_rdata[`RTCF_BATT_GOOD_BIT] = BACKUP_ENERGY_GOOD;
            end
            default: begin
                reg_rdata = `RTCF_RST_BYTE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // bus drive
    // ------------------------------------------------------------
    // sram read has priority; register data is a snapshot taken at
    // the start of the read so the clear does not disturb it
    always @(posedge CLK_SYS) begin
        if (RST) begin
            MUXED_ADDR_DATA_BUS_OUT  <= `RTCF_RST_BYTE;
            MUXED_ADDR_DATA_BUS_OE_N <= 1'b1;
        end else if (!RAM_READ_ENABLE_N) begin
            MUXED_ADDR_DATA_BUS_OUT  <= ram_rdata;
            MUXED_ADDR_DATA_BUS_OE_N <= 1'b0;
        end else if (!CS_N && !RD_N) begin
            if (reg_rd_start) begin
                MUXED_ADDR_DATA_BUS_OUT <= reg_rdata;
            end
            MUXED_ADDR_DATA_BUS_OE_N <= 1'b0;
        end else begin
            MUXED_ADDR_DATA_BUS_OE_N <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // open-drain interrupt pin
    // ------------------------------------------------------------
    always @(posedge CLK_SYS) begin
        if (RST) begin
            IRQ_PIN_OUT  <= 1'b0;
            IRQ_PIN_OE_N <= 1'b1;
        end else begin
            IRQ_PIN_OUT  <= 1'b0;
            IRQ_PIN_OE_N <= ~request_pending_flag_d;
        end
    end

endmodule // rtcf_top

// ---- tb/rtcf_monitor.sv ----
// assertion checker on the ports of the flag and sram block
module rtcf_monitor (
    input wire        CLK_SYS,
    input wire        RST,
    input wire [7:0]  MUXED_ADDR_DATA_BUS_IN,
    input wire [7:0]  MUXED_ADDR_DATA_BUS_OUT,
    input wire        MUXED_ADDR_DATA_BUS_OE_N,
    input wire        ALE,
    input wire        CS_N,
    input wire        RD_N,
    input wire        WR_N,
    input wire        LOW_ADDR_STROBE_N,
    input wire        HIGH_ADDR_STROBE_N,
    input wire        RAM_READ_ENABLE_N,
    input wire        RAM_STORE_ENABLE_N,
    input wire [15:0] DIVIDER_TAPS,
    input wire        ALARM_MATCH,
    input wire        UPDATE_DONE,
    input wire        POWER_GOOD,
    input wire        BACKUP_ENERGY_GOOD,
    input wire        IRQ_PIN_OUT,
    input wire        IRQ_PIN_OE_N
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    sequence reg_rd_s;
        !CS_N && !RD_N && RAM_READ_ENABLE_N;
    endsequence
    sequence idle_bus_s;
        RAM_READ_ENABLE_N && (CS_N || RD_N);
    endsequence
    // event pins are seen one edge before the pin falls
    sequence flag_cause_s;
        $past(ALARM_MATCH) || $past(UPDATE_DONE)
        || $past(!WR_N) || $past(!WR_N, 2) || $past(!WR_N, 3)
        || DIVIDER_TAPS != $past(DIVIDER_TAPS)
        || $past(DIVIDER_TAPS) != $past(DIVIDER_TAPS, 2)
        || $past(DIVIDER_TAPS, 2) != $past(DIVIDER_TAPS, 3);
    endsequence
    sequence flag_clear_s;
        (!CS_N && !RD_N) || $past(!CS_N && !RD_N) || $past(!WR_N) || $past(!WR_N, 2);
    endsequence
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    irq_level_a: assert property (IRQ_PIN_OUT == 1'b0)
        else $error("interrupt pin drives a high level");
    irq_cause_a: assert property ($fell(IRQ_PIN_OE_N) |-> flag_cause_s)
        else $error("interrupt asserted without an event");
    irq_release_a: assert property ($rose(IRQ_PIN_OE_N) |-> flag_clear_s)
        else $error("interrupt released without a read or write");
    reg_answer_a: assert property (reg_rd_s |=> !MUXED_ADDR_DATA_BUS_OE_N)
        else $error("register read not answered");
    ram_drive_a: assert property (!RAM_READ_ENABLE_N |=> !MUXED_ADDR_DATA_BUS_OE_N)
        else $error("sram read not driven");
    bus_release_a: assert property (idle_bus_s |=> MUXED_ADDR_DATA_BUS_OE_N)
        else $error("bus driven with no reader");
    read_hold_a: assert property (reg_rd_s [*3] |-> $stable(MUXED_ADDR_DATA_BUS_OUT))
        else $error("register read data changed");
    reset_quiet_a: assert property (disable iff (1'b0)
        RST |=> MUXED_ADDR_DATA_BUS_OE_N && IRQ_PIN_OE_N)
        else $error("outputs active in reset");
endmodule // rtcf_monitor

bind rtcf_top rtcf_monitor i_mon (.CLK_SYS, .RST, .MUXED_ADDR_DATA_BUS_IN,
    .MUXED_ADDR_DATA_BUS_OUT, .MUXED_ADDR_DATA_BUS_OE_N, .ALE, .CS_N, .RD_N, .WR_N,
    .LOW_ADDR_STROBE_N, .HIGH_ADDR_STROBE_N, .RAM_READ_ENABLE_N, .RAM_STORE_ENABLE_N,
    .DIVIDER_TAPS, .ALARM_MATCH, .UPDATE_DONE, .POWER_GOOD, .BACKUP_ENERGY_GOOD,
    .IRQ_PIN_OUT, .IRQ_PIN_OE_N);

// ---- tb/rtcf_host.sv ----
// host processor model on the multiplexed bus
module rtcf_host (
    input  logic       clk,
    input  logic [7:0] dev_out,
    input  logic       dev_oe_n,
    output logic [7:0] bus,
    output logic       ale,
    output logic       cs_n,
    output logic       rd_n,
    output logic       wr_n,
    output logic       las_n,
    output logic       has_n,
    output logic       oer_n,
    output logic       wer_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] drv;
    logic       en;
    // released bus shows the inverse of the last driven value
    assign bus = !dev_oe_n ? dev_out : (en ? drv : ~drv);
    initial begin
        {ale, drv, en} = '0;
        {cs_n, rd_n, wr_n, las_n, has_n, oer_n, wer_n} = '1;
    end
    // ------------------------------------------------------------
    // bus cycles, one strobe active at a time
    // ------------------------------------------------------------
    task automatic pulse(input int s, input logic [7:0] v);
        @(negedge clk);
        drv = v;
        en = 1;
        case (s)
            0: ale = 1;
            1: las_n = 0;
            2: has_n = 0;
            3: {cs_n, wr_n} = 2'b00;
            default: wer_n = 0;
        endcase
        @(negedge clk);
        {ale, las_n, has_n, wr_n, wer_n} = 5'b01111;
        @(negedge clk);
        cs_n = 1;
        en = 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        pulse(0, a);
        pulse(3, d);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        pulse(0, a);
        @(negedge clk);
        {cs_n, rd_n} = 2'b00;
        @(negedge clk);
        d = bus;
        repeat (2) @(negedge clk);
        {cs_n, rd_n} = 2'b11;
    endtask
    // halves not asked for in m keep their latched value
    task automatic adr(input logic [11:0] a, input logic [1:0] m);
        if (m[0]) pulse(1, a[7:0]);
        if (m[1]) pulse(2, {4'h0, a[11:8]});
    endtask
    task automatic sw(input logic [11:0] a, input logic [7:0] d, input logic [1:0] m);
        adr(a, m);
        pulse(4, d);
    endtask
    task automatic sr(input logic [11:0] a, input logic [1:0] m, output logic [7:0] d);
        adr(a, m);
        @(negedge clk);
        oer_n = 0;
        repeat (2) @(negedge clk);
        d = bus;
        @(negedge clk);
        oer_n = 1;
    endtask
endmodule // rtcf_host

// ---- tb/tb.sv ----
// self-checking bench of the flag and sram port block
`include "rtcf_defs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED at %0t got %h expected %h", $time, g, e); end end
    logic        clk, rst, ale, cs_n, rd_n, wr_n, las_n, has_n, oer_n, wer_n;
    logic        bus_oe_n, alarm, upd, pgood, batt, irq_out, irq_oe_n;
    logic [7:0]  bus_in, bus_out, d;
    logic [15:0] taps;
    int          n_errors = 0;
    int          n_compared = 0;
    logic [7:0]  a_rt = `RTCF_ADDR_RATE_CTRL;
    logic [7:0]  a_ct = `RTCF_ADDR_MAIN_CTRL;
    logic [7:0]  a_fl = `RTCF_ADDR_IRQ_FLAGS;
    logic [19:0] rows [4] = '{20'h000A5, 20'hFFF5A, 20'h5A33C, 20'hA5CC3};
    logic [10:0] evs [3] = '{11'h2A0, 11'h190, 11'h4C0};
    rtcf_top i_dut (.CLK_SYS(clk), .RST(rst), .MUXED_ADDR_DATA_BUS_IN(bus_in),
        .MUXED_ADDR_DATA_BUS_OUT(bus_out), .MUXED_ADDR_DATA_BUS_OE_N(bus_oe_n),
        .ALE(ale), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n), .LOW_ADDR_STROBE_N(las_n),
        .HIGH_ADDR_STROBE_N(has_n), .RAM_READ_ENABLE_N(oer_n), .RAM_STORE_ENABLE_N(wer_n),
        .DIVIDER_TAPS(taps), .ALARM_MATCH(alarm), .UPDATE_DONE(upd), .POWER_GOOD(pgood),
        .BACKUP_ENERGY_GOOD(batt), .IRQ_PIN_OUT(irq_out), .IRQ_PIN_OE_N(irq_oe_n));
    rtcf_host i_host (.clk(clk), .dev_out(bus_out), .dev_oe_n(bus_oe_n), .bus(bus_in),
        .ale(ale), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .las_n(las_n), .has_n(has_n),
        .oer_n(oer_n), .wer_n(wer_n));
    // ------------------------------------------------------------
    // clock, event source, closing
    // ------------------------------------------------------------
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // k = {tap rise, alarm, update}
    task automatic ev(input logic [2:0] k);
        @(negedge clk);
        {alarm, upd} = k[1:0];
        taps = 16'h0000;
        @(negedge clk);
        {alarm, upd} = 2'b00;
        taps[3] = k[2];
        repeat (2) @(negedge clk);
    endtask
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #100us;
        n_errors++;
        summarize();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        {taps, alarm, upd} = '0;
        {pgood, batt, rst} = 3'b111;
        repeat (2) @(negedge clk);
        rst = 0;
        `CHK({bus_oe_n, irq_oe_n, irq_out}, 3'b110)
        foreach (rows[i]) i_host.sw(rows[i][19:8], rows[i][7:0], 2'b11);
        foreach (rows[i]) begin
            i_host.sr(rows[i][19:8], 2'b11, d);
            `CHK(d, rows[i][7:0])
        end
        $display("test sram rows done");
        i_host.wr(a_rt, 8'h03);
        i_host.wr(a_ct, 8'h70);
        foreach (evs[i]) begin
            ev(evs[i][10:8]);
            `CHK(irq_oe_n, 1'b0)
            i_host.rd(a_fl, d);
            `CHK(d, evs[i][7:0])
            `CHK(irq_oe_n, 1'b1)
            i_host.rd(a_fl, d);
            `CHK(d, 8'h00)
        end
        $display("test flag rows done");
        i_host.sw(12'h3C7, 8'h11, 2'b11);
        i_host.sw(12'h3C8, 8'h22, 2'b01);
        i_host.sr(12'h3C7, 2'b01, d);
        `CHK(d, 8'h11)
        pgood = 0;
        i_host.sw(12'h3C8, 8'hEE, 2'b11);
        pgood = 1;
        i_host.sr(12'h3C8, 2'b00, d);
        `CHK(d, 8'h22)
        $display("test sram latch and protect done");
        i_host.rd(`RTCF_ADDR_BATT_STATUS, d);
        `CHK(d, 8'h80)
        batt = 0;
        i_host.wr(`RTCF_ADDR_BATT_STATUS, 8'hFF);
        i_host.rd(`RTCF_ADDR_BATT_STATUS, d);
        `CHK(d, 8'h00)
        i_host.wr(a_fl, 8'hFF);
        i_host.rd(a_fl, d);
        `CHK(d, 8'h00)
        $display("test read-only registers done");
        i_host.wr(a_ct, 8'h30);
        ev(3'b100);
        `CHK(irq_oe_n, 1'b1)
        i_host.rd(a_fl, d);
        `CHK(d, 8'h40)
        i_host.wr(a_ct, 8'hF0);
        i_host.rd(a_ct, d);
        `CHK(d, 8'hE0)
        ev(3'b001);
        `CHK(irq_oe_n, 1'b1)
        i_host.rd(a_fl, d);
        `CHK(d, 8'h10)
        $display("test enables and freeze done");
        i_host.wr(a_ct, 8'h20);
        fork
            i_host.rd(a_fl, d);
            begin
                repeat (4) @(negedge clk);
                alarm = 1;
                @(negedge clk);
                alarm = 0;
            end
        join
        `CHK(irq_oe_n, 1'b0)
        i_host.rd(a_fl, d);
        `CHK(d, 8'hA0)
        $display("test event during read done");
        summarize();
    end
endmodule // tb
